// ==== fdtc_consts.vh ====
// Constants for the flying die tolerance and cut control block.
// Assumes a 125 MHz pclk and an APB register bus with 32-bit words.
`ifndef FDTC_CONSTS_VH
`define FDTC_CONSTS_VH
`define FDTC_A_CTRL 12'h000
`define FDTC_A_TOL 12'h004
`define FDTC_A_RES 12'h008
`define FDTC_A_SCALE 12'h00C
`define FDTC_A_FILT 12'h010
`define FDTC_A_DWELL 12'h014
`define FDTC_A_OFFS 12'h018
`define FDTC_A_LOOP 12'h01C
`define FDTC_A_STAT 12'h020
`define FDTC_A_LEN 12'h024
`define FDTC_M_STOP_NO_CUT 2'h0
`define FDTC_M_CUT_STOP 2'h1
`define FDTC_M_WARN_ONLY 2'h2
`define FDTC_M_WARN_NO_CUT 2'h3
`define FDTC_RES_MIN 32'h00000FA0
`define FDTC_RES_MAX 32'h003D0900
`define FDTC_SCALE_RST 16'h2710
`define FDTC_FILT_RST 16'h0140
`define FDTC_FILT_MIN 16'h000A
`define FDTC_FILT_MAX 16'h07D0
`define FDTC_DWELL_MAX 14'h270F
`define FDTC_OFFS_INT_S 16'h0064
`define FDTC_MS_NS 32'h000F4240
`define FDTC_CLK_NS 32'h00000008
`define FDTC_MS_CYC (`FDTC_MS_NS / `FDTC_CLK_NS)
`define FDTC_QUAD 4
`define FDTC_BLINK_BIT 8
`endif

// ==== fdtc_cut_control.v ====
// Cut decision, tolerance reaction, dwell timing and parameter registers.
// Assumes APB master, synchronous pin inputs and host-computed length error.
// Functional notes
// - Stop-no-cut: check tolerance from min die distance, shear once met.
// - Stop-no-cut: unmet at max die distance posts error, halts, no shear.
// - Cut-and-stop: shear at min, test at dwell end, halt on failure.
// - Warn-only: always shear, line runs, test at dwell end, warn.
// - Warn-only warning stays latched until operator acknowledges.
// - Warn-no-cut: test in window; if unmet error, line runs, no cut.
// - Warn modes: manual crop only seeks die home, no standing cut.
// - Warn modes: manual shear arms flashing auto-crop, flying crop on run.
// - Numeric or selection key advances reaction mode through four choices.
// - Tolerance is symmetric band around target; outside triggers reaction.
// - Hold offset self-adjusts; operator write overrides starting value.
// - Drift-removal integral time defaults to 100 seconds.
// - Derivative value zero disables derivative contribution.
// - Key press toggles encoder direction, reversing the sign of each new count.
// - One quadrature count is circumference over four times line count.
// - Resolution accepted only from 0.00004 to 0.04 inch per count.
// - Length scale percent, 100 means none; larger gives longer parts.
// - Filter cutoff defaults 32 Hz, limited to 1.0 to 200.0 Hz.
// - Press dwell 0.000 to 9.999 s in ms, separate down and up.
// - Press-finished switch ends press cycle early over dwell timer.
// - Motor resolution offered only in two-encoder operation.
// - Manual press energises selected tool with its press and gag.
`timescale 1ns/1ps
`include "fdtc_consts.vh"
module fdtc_cut_control #(
    parameter MS_CYC = `FDTC_MS_CYC, // Clock cycles per millisecond
    parameter TOOLS = 8 // Number of selectable tools
) (
    input wire pclk, // Clock
    input wire presetn, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire run_mode, // Line is in run
    input wire die_past_min, // Die beyond minimum die distance
    input wire die_at_max, // Die at maximum die distance
    input wire [31:0] len_err, // Signed part length error, counts
    input wire mode_key, // Numeric or selection_key press, one pulse
    input wire dir_key, // Key press on direction setting, one pulse
    input wire manual_shear, // Manual shear or crop button, pulse
    input wire manual_press, // Manual press input, pulse
    input wire press_done_sw, // Press-finished switch closed
    input wire ack_key, // Operator acknowledge, pulse
    input wire enc_step, // Decoded encoder increment
    input wire enc_up, // Raw increment direction
    input wire [15:0] offs_adj, // Auto offset correction step, signed
    input wire offs_adj_vld, // Offset correction valid
    output reg shear_fire, // Shear output
    output reg line_halt, // Halt the line
    output reg seek_home, // Seek die home switch
    output reg autocrop_flash, // Auto-crop armed indication
    output reg tol_err, // Latched tolerance error
    output reg tol_warn, // Latched warning
    output reg press_on, // Press output
    output reg [TOOLS-1:0] gag_sel, // Selected tool gag
    output reg signed [31:0] position // Scaled signed position, counts
);
    localparam S_IDLE = 5'h01;
    localparam S_WIN = 5'h02;
    localparam S_DWELL = 5'h04;
    localparam S_UP = 5'h08;
    localparam S_DONE = 5'h10;
    localparam P_IDLE = 3'h1;
    localparam P_DOWN = 3'h2;
    localparam P_UP = 3'h4;
    // Blink bit of a millisecond counter; 2^8 ms half period gives roughly a 2 Hz flash
    localparam BLINK_BIT = `FDTC_BLINK_BIT;
    reg [4:0] st_q;
    reg [2:0] pst_q;
    reg [1:0] mode_q;
    reg dir_q;
    reg two_enc_q;
    reg autocrop_q;
    reg [31:0] tol_q;
    reg [31:0] res_q;
    reg [31:0] mres_q;
    reg [15:0] scale_q;
    reg [15:0] filt_q;
    reg [15:0] offs_q;
    reg [15:0] deriv_q;
    reg [15:0] oint_q;
    reg [13:0] dwd_q;
    reg [13:0] dwu_q;
    reg [13:0] shd_q;
    reg [7:0] tool_q;
    reg [13:0] ms_q;
    reg [31:0] tick_q;
    reg [31:0] acc_q;
    reg [BLINK_BIT:0] blink_q;
    wire [TOOLS-1:0] tool_hot;
    // Magnitude of the length error; the band is symmetric about target
    wire [31:0] abs_err = len_err[31] ? (~len_err + 32'h00000001) : len_err;
    wire in_tol = abs_err <= tol_q;
    wire warn_mode = mode_q[1];
    wire wr = psel & penable & pwrite & pready;
    function [13:0] dwell_clip;
        input [31:0] v;
        begin
            dwell_clip = (v > {18'h0, `FDTC_DWELL_MAX}) ? `FDTC_DWELL_MAX : v[13:0];
        end
    endfunction
    function [15:0] filt_clip;
        input [31:0] v;
        begin
            if (v[31:16] != 16'h0 || v[15:0] > `FDTC_FILT_MAX) begin
                filt_clip = `FDTC_FILT_MAX;
            end else if (v[15:0] < `FDTC_FILT_MIN) begin
                filt_clip = `FDTC_FILT_MIN;
            end else begin
                filt_clip = v[15:0];
            end
        end
    endfunction
    wire ms_tick = (tick_q == MS_CYC - 1);
    // Tool decode over the whole tool number, so an out-of-range tool selects no gag
    genvar gi;
    generate
        for (gi = 0; gi < TOOLS; gi = gi + 1) begin : g_tool
            assign tool_hot[gi] = ({24'h000000, tool_q} == gi);
        end
    endgenerate
    // APB slave, zero wait, registers and key-driven settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            mode_q <= `FDTC_M_STOP_NO_CUT;
            dir_q <= 1'b0;
            two_enc_q <= 1'b0;
            tol_q <= 32'h00000000;
            res_q <= `FDTC_RES_MIN;
            mres_q <= `FDTC_RES_MIN;
            scale_q <= `FDTC_SCALE_RST;
            filt_q <= `FDTC_FILT_RST;
            dwd_q <= 14'h0000;
            dwu_q <= 14'h0000;
            shd_q <= 14'h0000;
            tool_q <= 8'h00;
            offs_q <= 16'h0000;
            deriv_q <= 16'h0000;
            oint_q <= `FDTC_OFFS_INT_S;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            // Keys and adjustments first; a same-cycle APB write below takes priority
            if (mode_key) begin
                mode_q <= mode_q + 2'h1;
            end
            if (dir_key) begin
                dir_q <= ~dir_q;
            end
            if (offs_adj_vld) begin
                offs_q <= offs_q + offs_adj;
            end
            if (psel & ~penable) begin
                case (paddr)
                    `FDTC_A_CTRL: prdata <= {tool_q, 20'h0, two_enc_q, dir_q, mode_q};
                    `FDTC_A_TOL: prdata <= tol_q;
                    `FDTC_A_RES: prdata <= two_enc_q ? mres_q : res_q;
                    `FDTC_A_SCALE: prdata <= {filt_q, scale_q};
                    `FDTC_A_FILT: prdata <= {16'h0, filt_q};
                    `FDTC_A_DWELL: prdata <= {4'h0, shd_q, dwd_q};
                    `FDTC_A_OFFS: prdata <= {oint_q, offs_q};
                    `FDTC_A_LOOP: prdata <= {2'h0, dwu_q, deriv_q};
                    `FDTC_A_STAT: prdata <= {26'h0, autocrop_q, tol_warn, tol_err, line_halt, press_on, shear_fire};
                    `FDTC_A_LEN: prdata <= position;
                    default: prdata <= 32'h00000000;
                endcase
                pslverr <= (paddr > `FDTC_A_LEN) | (paddr[1:0] != 2'h0);
            end
            if (wr && paddr[1:0] == 2'h0) begin
                case (paddr)
                    `FDTC_A_CTRL: begin
                        tool_q <= pwdata[31:24];
                        two_enc_q <= pwdata[3];
                        dir_q <= pwdata[2];
                        mode_q <= pwdata[1:0];
                    end
                    `FDTC_A_TOL: tol_q <= pwdata;
                    `FDTC_A_RES: begin
                        if (pwdata >= `FDTC_RES_MIN && pwdata <= `FDTC_RES_MAX) begin
                            if (two_enc_q) begin
                                mres_q <= pwdata;
                            end else begin
                                res_q <= pwdata;
                            end
                        end
                    end
                    `FDTC_A_SCALE: scale_q <= pwdata[15:0];
                    `FDTC_A_FILT: filt_q <= filt_clip(pwdata);
                    `FDTC_A_DWELL: begin
                        dwd_q <= dwell_clip({18'h0, pwdata[13:0]});
                        shd_q <= dwell_clip({18'h0, pwdata[27:14]});
                    end
                    `FDTC_A_OFFS: begin
                        offs_q <= pwdata[15:0];
                        oint_q <= pwdata[31:16];
                    end
                    `FDTC_A_LOOP: begin
                        deriv_q <= pwdata[15:0];
                        dwu_q <= dwell_clip({18'h0, pwdata[29:16]});
                    end
                    default: ;
                endcase
            end
        end
    end
    // Position: each quadrature count is one resolution unit, scaled by percent in 0.01 % units
    // Exact divide keeps 100 % a true identity; it costs a wide combinational path
    wire signed [47:0] scaled = $signed(acc_q) * $signed({1'b0, scale_q});
    wire signed [47:0] scaled_pct = scaled / $signed({32'h00000000, `FDTC_SCALE_RST});
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 32'h00000000;
            position <= 32'sh00000000;
        end else begin
            if (enc_step) begin
                acc_q <= (enc_up ^ dir_q) ? acc_q + 32'h00000001 : acc_q - 32'h00000001;
            end
            position <= scaled_pct[31:0];
        end
    end
    // Millisecond timebase shared by shear and press dwell
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 32'h00000000;
        end else begin
            tick_q <= ms_tick ? 32'h00000000 : tick_q + 32'h00000001;
        end
    end
    // Flash timebase in milliseconds, free running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_q <= {(BLINK_BIT + 1){1'b0}};
        end else if (ms_tick) begin
            blink_q <= blink_q + 1'b1;
        end
    end
    // Cut sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            ms_q <= 14'h0000;
            shear_fire <= 1'b0;
            line_halt <= 1'b0;
            seek_home <= 1'b0;
            autocrop_q <= 1'b0;
            autocrop_flash <= 1'b0;
            tol_err <= 1'b0;
            tol_warn <= 1'b0;
        end else begin
            seek_home <= 1'b0;
            autocrop_flash <= autocrop_q & blink_q[BLINK_BIT];
            if (ack_key) begin
                tol_err <= 1'b0;
                tol_warn <= 1'b0;
                line_halt <= 1'b0;
            end
            if (manual_shear && warn_mode && !run_mode) begin
                seek_home <= 1'b1;
                autocrop_q <= 1'b1;
            end
            case (st_q)
                S_IDLE: if (run_mode && die_past_min) begin
                    if (autocrop_q || mode_q == `FDTC_M_CUT_STOP || mode_q == `FDTC_M_WARN_ONLY) begin
                        autocrop_q <= 1'b0;
                        shear_fire <= 1'b1;
                        ms_q <= 14'h0000;
                        st_q <= autocrop_q ? S_UP : S_DWELL;
                    end else begin
                        st_q <= S_WIN;
                    end
                end
                S_WIN: begin
                    if (in_tol) begin
                        shear_fire <= 1'b1;
                        ms_q <= 14'h0000;
                        st_q <= S_UP;
                    end else if (die_at_max) begin
                        tol_err <= 1'b1;
                        if (mode_q == `FDTC_M_STOP_NO_CUT) begin
                            line_halt <= 1'b1;
                        end
                        st_q <= S_DONE;
                    end
                end
                S_DWELL: begin
                    if (ms_tick) begin
                        ms_q <= ms_q + 14'h0001;
                    end
                    if (ms_q >= shd_q) begin
                        if (!in_tol) begin
                            tol_err <= 1'b1;
                            if (mode_q == `FDTC_M_WARN_ONLY) begin
                                tol_warn <= 1'b1;
                            end else begin
                                line_halt <= 1'b1;
                            end
                        end
                        shear_fire <= 1'b0;
                        st_q <= S_DONE;
                    end
                end
                S_UP: begin
                    if (ms_tick) begin
                        ms_q <= ms_q + 14'h0001;
                    end
                    if (ms_q >= shd_q) begin
                        shear_fire <= 1'b0;
                        st_q <= S_DONE;
                    end
                end
                // Wait for the die to return so that one window gives one decision
                S_DONE: if (!die_past_min) begin
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    // Press sequencer
    reg [13:0] pms_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_q <= P_IDLE;
            pms_q <= 14'h0000;
            press_on <= 1'b0;
            gag_sel <= {TOOLS{1'b0}};
        end else begin
            if (ms_tick) begin
                pms_q <= pms_q + 14'h0001;
            end
            case (pst_q)
                P_IDLE: if (manual_press) begin
                    press_on <= 1'b1;
                    gag_sel <= tool_hot;
                    pms_q <= 14'h0000;
                    pst_q <= P_DOWN;
                end
                P_DOWN: if (press_done_sw || pms_q >= dwd_q) begin
                    press_on <= 1'b0;
                    pms_q <= 14'h0000;
                    pst_q <= P_UP;
                end
                // Up dwell keeps the gag held until the press is clear
                P_UP: if (pms_q >= dwu_q) begin
                    gag_sel <= {TOOLS{1'b0}};
                    pst_q <= P_IDLE;
                end
                default: pst_q <= P_IDLE;
            endcase
        end
    end
endmodule // fdtc_cut_control

// ==== fdtc_checker.sv ====
// Port checker for the tolerance cut control block.
// Assumes it is bound onto fdtc_cut_control and sees only its ports.
`timescale 1ns/1ps
module fdtc_checker #(
    parameter TOOLS = 8
) (
    input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, len_err,
    input wire run_mode, die_past_min, mode_key, manual_shear, manual_press, press_done_sw, ack_key,
    input wire shear_fire, line_halt, seek_home, tol_err, tol_warn, press_on,
    input wire [TOOLS-1:0] gag_sel
);
    logic [1:0] mode_q;
    logic [31:0] tol_q;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire [31:0] err_abs = len_err[31] ? -len_err : len_err;
    // Mirror of the reaction mode and band, so rules can be judged per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            tol_q <= 32'h0;
        end else begin
            if (wr_ok && paddr == 12'h000) mode_q <= pwdata[1:0];
            else if (mode_key) mode_q <= mode_q + 2'h1;
            if (wr_ok && paddr == 12'h004) tol_q <= pwdata;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_home_pulse;
        seek_home ##1 !seek_home;
    endsequence
    a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready in access");
    a_apb_refuse: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 12'h024) |=> pslverr)
        else $error("bad address not refused");
    a_stop_hold: assert property (mode_q == 2'h0 && run_mode && die_past_min && err_abs > tol_q && !shear_fire
        |=> !shear_fire) else $error("shear out of band");
    a_cut_fires: assert property ($rose(die_past_min) && run_mode && mode_q == 2'h1 |=> shear_fire)
        else $error("no cut at min");
    a_shear_window: assert property ($rose(shear_fire) |-> $past(die_past_min)) else $error("shear outside window");
    a_warn_nohalt: assert property (mode_q[1] && !line_halt |=> !line_halt) else $error("halt in warn mode");
    a_warn_latch: assert property (tol_warn && !ack_key |=> tol_warn) else $error("warning lost");
    a_err_latch: assert property (tol_err && !ack_key |=> tol_err) else $error("error lost");
    a_ack_clears: assert property (ack_key && !run_mode && !die_past_min |=> !tol_err && !tol_warn)
        else $error("ack did not clear");
    a_crop_home: assert property (mode_q[1] && manual_shear && !run_mode |=> s_home_pulse and !shear_fire)
        else $error("manual crop cut");
    a_press_gag: assert property (manual_press && !press_on && gag_sel == '0 |=> press_on && gag_sel != '0)
        else $error("press not energised");
    a_press_done: assert property (press_on && press_done_sw |-> ##[1:2] !press_on)
        else $error("press switch ignored");
endmodule // fdtc_checker
bind fdtc_cut_control fdtc_checker #(.TOOLS(TOOLS)) fdtc_checker_inst (.*);

// ==== fdtc_far_side.sv ====
// Far side model: die carriage travel and press-finished switch.
// Assumes the bench raises go for one flying cut and drops it after.
`timescale 1ns/1ps
module fdtc_far_side #(
    parameter MIN_POS = 20,
    parameter MAX_POS = 60,
    parameter PRESS_CYC = 15
) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire go, // Target coming, die travels
    input wire press_on, // Press output
    output logic die_past_min, // Die past minimum distance
    output logic die_at_max, // Die at maximum distance
    output logic press_done_sw // Press-finished switch
);
    logic [7:0] die_q;
    logic [7:0] prs_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            die_q <= 8'h00;
            prs_q <= 8'h00;
        end else begin
            // Die parks short of the end stop, returns home when go drops
            die_q <= !go ? 8'h00 : (die_q < 8'h5A ? die_q + 8'h01 : die_q);
            prs_q <= press_on ? prs_q + 8'h01 : 8'h00;
        end
    end
    assign die_past_min = die_q >= MIN_POS;
    assign die_at_max = die_q >= MAX_POS;
    assign press_done_sw = prs_q >= PRESS_CYC;
endmodule // fdtc_far_side

// ==== flying_die_tolerance_cut_control_tb_top.sv ====
// Self-checking bench for the tolerance cut control block.
// Assumes fdtc_consts.vh on the include path and the far side model.
`timescale 1ns/1ps
`include "fdtc_consts.vh"
module flying_die_tolerance_cut_control_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run_mode = 0, go = 0;
    logic mode_key = 0, dir_key = 0, manual_shear = 0, manual_press = 0, ack_key = 0;
    logic enc_step = 0, enc_up = 1, offs_adj_vld = 0, seen = 0, flashed = 0, perr;
    logic [11:0] paddr = 12'h000;
    logic [15:0] offs_adj = 16'h0000;
    logic [31:0] pwdata = 32'h0, len_err = 32'h0, prdata, rd;
    logic pready, pslverr, die_past_min, die_at_max, press_done_sw, shear_fire, line_halt, seek_home;
    logic autocrop_flash, tol_err, tol_warn, press_on;
    logic [7:0] gag_sel;
    logic signed [31:0] position;
    integer errors = 0, samples_checked = 0;
    fdtc_cut_control #(.MS_CYC(10), .TOOLS(8)) fdtc_cut_control_inst (.*);
    fdtc_far_side fdtc_far_side_inst (.*);
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (shear_fire === 1'b1) seen = 1'b1;
    always @(posedge pclk) if (autocrop_flash === 1'b1) flashed = 1'b1;
    task automatic chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input [11:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr_rd(input [11:0] a, input [31:0] d, input [31:0] m, input [31:0] exp);
        apb(1, a, d);
        apb(0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    // Pulse order: mode_key, dir_key, manual_shear, manual_press, ack_key
    task automatic kick(input [4:0] k);
        {mode_key, dir_key, manual_shear, manual_press, ack_key} <= k;
        @(posedge pclk);
        {mode_key, dir_key, manual_shear, manual_press, ack_key} <= 5'h00;
        @(posedge pclk);
    endtask
    // One flying cut; expect is {shear seen, error, halt, warning}
    task automatic cut(input [1:0] m, input [31:0] e, input [3:0] exp);
        apb(1, `FDTC_A_CTRL, {8'h03, 22'h002, m});
        seen = 1'b0;
        len_err <= e;
        run_mode <= 1'b1;
        go <= 1'b1;
        cyc(110);
        @(negedge pclk);
        chk({seen, tol_err, line_halt, tol_warn}, exp);
        @(posedge pclk);
        go <= 1'b0;
        run_mode <= 1'b0;
        cyc(3);
        kick(5'h01);
        @(negedge pclk);
        chk({tol_err, line_halt, tol_warn}, 3'h0);
        @(posedge pclk);
    endtask
    initial begin
        cyc(2);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `FDTC_A_SCALE, 32'h0);
        chk(rd, {`FDTC_FILT_RST, `FDTC_SCALE_RST});
        apb(0, `FDTC_A_OFFS, 32'h0);
        chk(rd[31:16], `FDTC_OFFS_INT_S);
        apb(0, 12'h028, 32'h0);
        chk(perr, 1'b1);
        apb(1, 12'h002, 32'h0);
        chk(perr, 1'b1);
        wr_rd(`FDTC_A_FILT, 32'h0, 32'hFFFF, `FDTC_FILT_MIN);
        wr_rd(`FDTC_A_FILT, 32'h1388, 32'hFFFF, `FDTC_FILT_MAX);
        apb(1, `FDTC_A_CTRL, 32'h03000008);
        wr_rd(`FDTC_A_RES, 32'h00001000, 32'hFFFFFFFF, 32'h00001000);
        wr_rd(`FDTC_A_RES, 32'h00000F9F, 32'hFFFFFFFF, 32'h00001000);
        wr_rd(`FDTC_A_RES, 32'h003D0901, 32'hFFFFFFFF, 32'h00001000);
        wr_rd(`FDTC_A_OFFS, 32'h00640100, 32'hFFFF, 32'h0100);
        offs_adj <= 16'h0005;
        offs_adj_vld <= 1'b1;
        @(posedge pclk);
        offs_adj_vld <= 1'b0;
        wr_rd(`FDTC_A_OFFS, 32'h00640100, 32'hFFFF, 32'h0100);
        offs_adj_vld <= 1'b1;
        @(posedge pclk);
        offs_adj_vld <= 1'b0;
        apb(0, `FDTC_A_OFFS, 32'h0);
        chk(rd[15:0], 16'h0105);
        wr_rd(`FDTC_A_DWELL, 32'h0000A70F, 32'h0FFFFFFF, 32'h0000A70F);
        wr_rd(`FDTC_A_LOOP, 32'h00010000, 32'h3FFFFFFF, 32'h00010000);
        for (int i = 1; i <= 4; i++) begin
            kick(5'h10);
            apb(0, `FDTC_A_CTRL, 32'h0);
            chk(rd[1:0], i[1:0]);
        end
        apb(1, `FDTC_A_SCALE, {16'h0000, `FDTC_SCALE_RST});
        enc_step <= 1'b1;
        cyc(4);
        enc_step <= 1'b0;
        cyc(3);
        chk(position, 32'h4);
        kick(5'h08);
        apb(0, `FDTC_A_CTRL, 32'h0);
        chk(rd[2], 1'b1);
        enc_step <= 1'b1;
        cyc(4);
        enc_step <= 1'b0;
        cyc(3);
        chk(position, 32'h0);
        apb(1, `FDTC_A_TOL, 32'hA);
        cut(`FDTC_M_STOP_NO_CUT, 32'h3, 4'h8);
        cut(`FDTC_M_STOP_NO_CUT, 32'h32, 4'h6);
        cut(`FDTC_M_CUT_STOP, 32'h32, 4'hE);
        cut(`FDTC_M_WARN_ONLY, 32'h32, 4'hD);
        cut(`FDTC_M_WARN_NO_CUT, 32'h32, 4'h4);
        cut(`FDTC_M_WARN_NO_CUT, 32'hFFFFFFF6, 4'h8);
        seen = 1'b0;
        kick(5'h04);
        cyc(2);
        chk(seen, 1'b0);
        apb(0, `FDTC_A_STAT, 32'h0);
        chk(rd[5], 1'b1);
        cyc(2600);
        chk(flashed, 1'b1);
        cut(`FDTC_M_WARN_NO_CUT, 32'h32, 4'h8);
        kick(5'h02);
        @(negedge pclk);
        chk({press_on, gag_sel}, 9'h108);
        cyc(25);
        chk(press_on, 1'b0);
        cyc(30);
        chk(gag_sel, 8'h00);
        end_of_test();
    end
    initial begin
        repeat (50000) @(posedge pclk);
        errors = errors + 1;
        end_of_test();
    end
endmodule // flying_die_tolerance_cut_control_tb_top
